/* File: hdl/wcl_pkg.sv */
package wcl_pkg;

    // ----------------------------------------
    // register numbers and field layout
    // ----------------------------------------
    localparam logic [7:0] REG_CS_ADDR = 8'h2C;
    localparam logic [7:0] REG_CS_DATA = 8'h2D;
    localparam logic [7:0] REG_BRK = 8'h32;
    localparam int CTR_LSB = 0;
    localparam int ADDR_LSB = 2;
    localparam int ADDR_W = 13;
    localparam int PIN_BIT = 16;
    localparam int BLK_LSB = 10;
    localparam int BLK_N = 8;
    localparam int DIAG_BLK = 4;
    localparam int WORD_W = 96;
    localparam int PAR_W = 3;
    localparam int PART_W = 32;
    localparam logic [1:0] LAST_PART = 2'h2;
    localparam logic [BLK_N-1:0] WRITABLE_DEF = 8'hF0;
    localparam int FIFO_W = 48;
    localparam int FIFO_D = 4;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [1:0] part;
        logic pin;
        logic [PART_W-1:0] data;
    } wcl_wr_t;

    typedef struct packed {
        logic [PAR_W-1:0] par;
        logic [WORD_W-1:0] data;
    } wcl_word_t;

endpackage

/* File: hdl/wcl_fifo.sv */
`timescale 1ns/10ps
module wcl_fifo #(
    parameter int W = 48,
    parameter int D = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW:0] wr_reg;
    logic [AW:0] rd_reg;
    logic full;
    logic empty;

    assign full = (wr_reg[AW] != rd_reg[AW]) &&
        (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
    assign empty = wr_reg == rd_reg;
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[rd_reg[AW-1:0]];

    always_ff @(posedge clk) begin
        if (in_valid && !full) begin
            mem[wr_reg[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_reg <= '0;
        end else if (in_valid && !full) begin
            wr_reg <= wr_reg + 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_reg <= '0;
        end else if (out_ready && !empty) begin
            rd_reg <= rd_reg + 1'b1;
        end
    end
endmodule

/* File: hdl/wcl_loader.sv */
`timescale 1ns/10ps
// Overview of operation
// - data register read returns writable block map
// - block index is word address bits 12:10
// - block 4 reserved for diagnostic microcode
// - control store word: 96 data, 3 parity
// - each data write stores piece, advances counter
// - data write with counter at 2 clears it, address increments
// - parity invert bit inverts stored parity
// - bad parity on fetch from a writable block raises machine check
// - address register has no reset value
// - microbreak asserted when micro pc matches
// - stop enabled: microbreak stops processor clock
// - stop disabled: microbreak only scope point
// - breakpoint register has no reset value
module wcl_loader (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_NUM,
    input wire logic [31:0] REG_WDATA,
    output logic [31:0] REG_RDATA,
    output logic REG_READY,
    input wire logic [wcl_pkg::ADDR_W-1:0] UPC,
    input wire logic UPC_FETCH,
    output logic [wcl_pkg::WORD_W-1:0] UWORD,
    output logic MACHINE_CHECK,
    output logic MICRO_BREAK,
    input wire logic STOP_ON_BREAK,
    output logic CLOCK_STOP
);
    // ----------------------------------------
    // storage and state
    // ----------------------------------------
    localparam int DEPTH = wcl_pkg::BLK_N << wcl_pkg::BLK_LSB;
    wcl_pkg::wcl_word_t cs_mem [DEPTH];
    logic [wcl_pkg::ADDR_W-1:0] addr_reg;
    logic [1:0] part_reg;
    logic pin_reg;
    logic [wcl_pkg::ADDR_W-1:0] brk_reg;
    logic [wcl_pkg::PART_W-1:0] lo_reg;
    logic [wcl_pkg::PART_W-1:0] mid_reg;
    logic stop_s1_reg;
    logic stop_s2_reg;
    logic [wcl_pkg::BLK_N-1:0] writable;
    wcl_pkg::wcl_wr_t wr_in;
    wcl_pkg::wcl_wr_t wr_out;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [wcl_pkg::FIFO_W-1:0] fifo_out;
    logic wr_data;
    logic wr_addr;

    assign writable = wcl_pkg::WRITABLE_DEF;

    function automatic logic [2:0] blk_of(
        input logic [wcl_pkg::ADDR_W-1:0] a
    );
        blk_of = a[wcl_pkg::ADDR_W-1:wcl_pkg::BLK_LSB];
    endfunction

    function automatic logic [wcl_pkg::PAR_W-1:0] par_of(
        input logic [wcl_pkg::WORD_W-1:0] d
    );
        logic [wcl_pkg::PAR_W-1:0] p;
        p = '0;
        for (int i = 0; i < wcl_pkg::PAR_W; i++) begin
            p[i] = ~^d[i*wcl_pkg::PART_W +: wcl_pkg::PART_W];
        end
        par_of = p;
    endfunction

    // ----------------------------------------
    // register access
    // ----------------------------------------
    // writes to the data register stall while the fifo is full
    assign REG_READY = !(REG_WR && REG_NUM == wcl_pkg::REG_CS_DATA)
        || fifo_in_ready;
    assign wr_data = REG_WR && REG_NUM == wcl_pkg::REG_CS_DATA &&
        fifo_in_ready;
    assign wr_addr = REG_WR && REG_NUM == wcl_pkg::REG_CS_ADDR;

    always_ff @(posedge SYS_CLK) begin
        if (wr_addr) begin
            addr_reg <= REG_WDATA[wcl_pkg::ADDR_LSB +: wcl_pkg::ADDR_W];
        end else if (wr_data && part_reg == wcl_pkg::LAST_PART) begin
            addr_reg <= addr_reg + 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            part_reg <= 2'h0;
            pin_reg <= 1'b0;
        end else if (wr_addr) begin
            part_reg <= REG_WDATA[wcl_pkg::CTR_LSB +: 2];
            pin_reg <= REG_WDATA[wcl_pkg::PIN_BIT];
        end else if (wr_data) begin
            if (part_reg == wcl_pkg::LAST_PART) begin
                part_reg <= 2'h0;
            end else begin
                part_reg <= part_reg + 2'h1;
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (REG_WR && REG_NUM == wcl_pkg::REG_BRK) begin
            brk_reg <= REG_WDATA[wcl_pkg::ADDR_W-1:0];
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            REG_RDATA <= 32'h0;
        end else if (REG_RD) begin
            unique case (REG_NUM)
                wcl_pkg::REG_CS_ADDR: begin
                    REG_RDATA <= {15'h0, pin_reg, 1'b0, addr_reg, part_reg};
                end
                wcl_pkg::REG_CS_DATA: begin
                    REG_RDATA <= {24'h0, writable};
                end
                wcl_pkg::REG_BRK: begin
                    REG_RDATA <= {19'h0, brk_reg};
                end
                default: begin
                    REG_RDATA <= 32'h0;
                end
            endcase
        end
    end

    // ----------------------------------------
    // write path through fifo
    // ----------------------------------------
    always_comb begin
        wr_in.addr = addr_reg;
        wr_in.part = part_reg;
        wr_in.pin = pin_reg;
        wr_in.data = REG_WDATA;
    end

    wcl_fifo #(
        .W(wcl_pkg::FIFO_W),
        .D(wcl_pkg::FIFO_D)
    ) u_fifo (
        .clk(SYS_CLK),
        .rst(RST),
        .in_valid(wr_data),
        .in_ready(fifo_in_ready),
        .in_data(wr_in),
        .out_valid(fifo_out_valid),
        .out_ready(1'b1),
        .out_data(fifo_out)
    );
    assign wr_out = fifo_out;

    always_ff @(posedge SYS_CLK) begin
        if (fifo_out_valid && wr_out.part == 2'h0) begin
            lo_reg <= wr_out.data;
        end
        if (fifo_out_valid && wr_out.part == 2'h1) begin
            mid_reg <= wr_out.data;
        end
    end

    // block 4 writable for diagnostic microcode like blocks 5 to 7
    always_ff @(posedge SYS_CLK) begin
        if (fifo_out_valid && wr_out.part == wcl_pkg::LAST_PART &&
                writable[blk_of(wr_out.addr)]) begin
            cs_mem[wr_out.addr].data <=
                {wr_out.data, mid_reg, lo_reg};
            cs_mem[wr_out.addr].par <=
                par_of({wr_out.data, mid_reg, lo_reg}) ^
                {wcl_pkg::PAR_W{wr_out.pin}};
        end
    end

    // ----------------------------------------
    // fetch, parity check, breakpoint
    // ----------------------------------------
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            UWORD <= '0;
            MACHINE_CHECK <= 1'b0;
        end else if (UPC_FETCH) begin
            UWORD <= cs_mem[UPC].data;
            MACHINE_CHECK <= writable[blk_of(UPC)] &&
                (par_of(cs_mem[UPC].data) != cs_mem[UPC].par);
        end else begin
            MACHINE_CHECK <= 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            stop_s1_reg <= 1'b0;
            stop_s2_reg <= 1'b0;
        end else begin
            stop_s1_reg <= STOP_ON_BREAK;
            stop_s2_reg <= stop_s1_reg;
        end
    end

    assign MICRO_BREAK = (UPC == brk_reg);
    assign CLOCK_STOP = MICRO_BREAK && stop_s2_reg;
endmodule

/* File: verif/wcl_loader_chk.sv */
`timescale 1ns/10ps
module wcl_loader_chk (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_NUM,
    input wire logic [31:0] REG_WDATA,
    input wire logic [31:0] REG_RDATA,
    input wire logic REG_READY,
    input wire logic [12:0] UPC,
    input wire logic UPC_FETCH,
    input wire logic MACHINE_CHECK,
    input wire logic MICRO_BREAK,
    input wire logic STOP_ON_BREAK,
    input wire logic CLOCK_STOP
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    // ----------------------------------------
    // shadow of breakpoint register
    // ----------------------------------------
    logic [12:0] brk_reg;
    logic brk_ok_reg;
    wire brk_wr = REG_WR && REG_NUM == wcl_pkg::REG_BRK;
    always_ff @(posedge SYS_CLK) begin
        if (brk_wr) begin
            brk_reg <= REG_WDATA[12:0];
        end
    end
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            brk_ok_reg <= 1'h0;
        end else if (brk_wr) begin
            brk_ok_reg <= 1'h1;
        end
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    sequence s_map_rd; REG_RD && REG_NUM == wcl_pkg::REG_CS_DATA; endsequence
    sequence s_low_fetch; UPC_FETCH && UPC[12:10] < 3'h4; endsequence
    sequence s_stop_held; STOP_ON_BREAK [*4]; endsequence
    sequence s_stop_off; !STOP_ON_BREAK [*4]; endsequence
    AST_MAP: assert property (
        s_map_rd |=> REG_RDATA == {24'h0, wcl_pkg::WRITABLE_DEF})
        else $error("map read wrong");
    AST_BLK: assert property (s_low_fetch |=> !MACHINE_CHECK)
        else $error("check on read-only block");
    AST_MC: assert property (MACHINE_CHECK |-> $past(UPC_FETCH))
        else $error("check without fetch");
    AST_BRK: assert property (
        brk_ok_reg |-> MICRO_BREAK == (UPC == brk_reg))
        else $error("break mismatch");
    AST_STOP: assert property (
        s_stop_held ##0 MICRO_BREAK |-> CLOCK_STOP)
        else $error("clock not stopped");
    AST_NOSTOP: assert property (s_stop_off |-> !CLOCK_STOP)
        else $error("clock stopped while disabled");
    AST_SRC: assert property (CLOCK_STOP |-> MICRO_BREAK)
        else $error("stop without break");
    AST_READY: assert property (
        !REG_READY |-> REG_WR && REG_NUM == wcl_pkg::REG_CS_DATA)
        else $error("ready low without data write");
endmodule
bind wcl_loader wcl_loader_chk chk (.SYS_CLK(SYS_CLK), .RST(RST),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_NUM(REG_NUM),
    .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .REG_READY(REG_READY),
    .UPC(UPC), .UPC_FETCH(UPC_FETCH), .MACHINE_CHECK(MACHINE_CHECK),
    .MICRO_BREAK(MICRO_BREAK), .STOP_ON_BREAK(STOP_ON_BREAK),
    .CLOCK_STOP(CLOCK_STOP));

/* File: verif/wcl_useq.sv */
`timescale 1ns/10ps
module wcl_useq (
    input wire logic clk,
    input wire logic go,
    input wire logic fetch_en,
    input wire logic [12:0] tgt,
    output logic [12:0] upc,
    output logic fetch
);
    initial begin
        upc = 13'h0;
        fetch = 1'h0;
    end
    // one fetch per go cycle with fetch_en set; pc parks on target
    always @(posedge clk) begin
        fetch <= go && fetch_en;
        if (go) begin
            upc <= tgt;
        end
    end
endmodule

/* File: verif/testbench.sv */
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fail_count++; \
    $display("unexpected t=%0t %h/%h", $time, a, b); end end
module testbench;
    logic SYS_CLK = 0, RST = 1, REG_WR = 0, REG_RD = 0, STOP_ON_BREAK = 0;
    logic go = 0, fen = 0, rd_d = 0, fd = 0;
    logic [7:0] REG_NUM = 8'h0;
    logic [31:0] REG_WDATA = 32'h0, REG_RDATA;
    logic REG_READY, UPC_FETCH, MACHINE_CHECK, MICRO_BREAK, CLOCK_STOP;
    logic [12:0] UPC, a, b, tgt = 13'h0;
    logic [95:0] UWORD, w, w0;
    logic [97:0] q[$];
    int fail_count = 0, compares = 0;
    always #2.5 SYS_CLK = ~SYS_CLK;
    wcl_loader uut (.SYS_CLK(SYS_CLK), .RST(RST), .REG_WR(REG_WR),
        .REG_RD(REG_RD), .REG_NUM(REG_NUM), .REG_WDATA(REG_WDATA),
        .REG_RDATA(REG_RDATA), .REG_READY(REG_READY), .UPC(UPC),
        .UPC_FETCH(UPC_FETCH), .UWORD(UWORD), .MACHINE_CHECK(MACHINE_CHECK),
        .MICRO_BREAK(MICRO_BREAK), .STOP_ON_BREAK(STOP_ON_BREAK),
        .CLOCK_STOP(CLOCK_STOP));
    wcl_useq seq (.clk(SYS_CLK), .go(go), .fetch_en(fen), .tgt(tgt),
        .upc(UPC), .fetch(UPC_FETCH));
    // ----------------------------------------
    // result watcher
    // ----------------------------------------
    always @(posedge SYS_CLK) begin
        rd_d <= REG_RD;
        fd <= UPC_FETCH;
    end
    always @(negedge SYS_CLK) begin
        if (rd_d) begin
            `CHK(REG_RDATA, q[0][31:0])
            void'(q.pop_front());
        end
        if (fd) begin
            if (q[0][97]) `CHK(UWORD, q[0][95:0])
            `CHK(MACHINE_CHECK, q[0][96])
            void'(q.pop_front());
        end
    end
    // ----------------------------------------
    // drivers
    // ----------------------------------------
    task wr(input logic [7:0] n, input logic [31:0] d);
        REG_WR <= 1;
        REG_RD <= 0;
        REG_NUM <= n;
        REG_WDATA <= d;
        do @(posedge SYS_CLK); while (REG_READY !== 1'h1);
    endtask
    task rd(input logic [7:0] n, input logic [31:0] e);
        REG_RD <= 1;
        REG_WR <= 0;
        REG_NUM <= n;
        q.push_back({66'h0, e});
        @(posedge SYS_CLK);
    endtask
    task idle(input int c);
        REG_WR <= 0;
        REG_RD <= 0;
        go <= 0;
        repeat (c) @(posedge SYS_CLK);
    endtask
    task load(input logic [12:0] ad, input logic p);
        wr(wcl_pkg::REG_CS_ADDR, {15'h0, p, 1'h0, ad, 2'h0});
        w = {$urandom, $urandom, $urandom};
        for (int i = 0; i < 3; i++) wr(wcl_pkg::REG_CS_DATA, w[i*32+:32]);
        idle(3);
    endtask
    task fetch(input logic [12:0] ad, input logic [97:0] e);
        go <= 1;
        fen <= 1;
        tgt <= ad;
        q.push_back(e);
        @(posedge SYS_CLK);
        idle(3);
    endtask
    task finish_test;
        $display("compares %0d, fails %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge SYS_CLK);
        fail_count++;
        finish_test;
    end
    initial begin
        void'($urandom(32'h758D));
        repeat (20) @(posedge SYS_CLK);
        RST <= 0;
        @(posedge SYS_CLK);
        rd(wcl_pkg::REG_CS_DATA, {24'h0, wcl_pkg::WRITABLE_DEF});
        rd(8'h0, 32'h0);
        idle(1);
        $display("map test done");
        a = {3'h4, 10'($urandom_range(0, 1000))};
        load(a, 1'h0);
        w0 = w;
        w = {$urandom, $urandom, $urandom};
        wr(wcl_pkg::REG_CS_DATA, w[31:0]);
        rd(wcl_pkg::REG_CS_ADDR, {15'h0, 2'h0, a + 13'h1, 2'h1});
        wr(wcl_pkg::REG_CS_DATA, w[63:32]);
        wr(wcl_pkg::REG_CS_DATA, w[95:64]);
        rd(wcl_pkg::REG_CS_ADDR, {15'h0, 2'h0, a + 13'h2, 2'h0});
        idle(3);
        fetch(a, {2'h2, w0});
        fetch(a + 13'h1, {2'h2, w});
        $display("load test done");
        b = {3'h7, 10'($urandom)};
        load(b, 1'h1);
        fetch(b, {2'h3, w});
        load(b, 1'h0);
        fetch(b, {2'h2, w});
        b = {3'h1, 10'($urandom_range(0, 1000))};
        load(b, 1'h1);
        fetch(b, 98'h0);
        rd(wcl_pkg::REG_CS_ADDR, {15'h0, 2'h2, b + 13'h1, 2'h0});
        idle(2);
        $display("parity test done");
        wr(wcl_pkg::REG_BRK, {19'h0, a});
        go <= 1;
        fen <= 0;
        tgt <= a;
        @(posedge SYS_CLK);
        idle(5);
        @(negedge SYS_CLK);
        `CHK({MICRO_BREAK, CLOCK_STOP}, 2'h2)
        @(posedge SYS_CLK);
        STOP_ON_BREAK <= 1;
        idle(5);
        @(negedge SYS_CLK);
        `CHK(CLOCK_STOP, 1'h1)
        @(posedge SYS_CLK);
        go <= 1;
        tgt <= a + 13'h1;
        @(posedge SYS_CLK);
        idle(2);
        @(negedge SYS_CLK);
        `CHK({MICRO_BREAK, CLOCK_STOP}, 2'h0)
        $display("break test done");
        @(posedge SYS_CLK);
        finish_test;
    end
endmodule
